// [src/dmas_params.svh]
// constants of the dual multiply-subtract unit
`ifndef DMAS_PARAMS_SVH
`define DMAS_PARAMS_SVH
`define OFS_MODE    8'h00
`define OFS_CMD     8'h04
`define OFS_XDATA   8'h08
`define OFS_CDATA   8'h0c
`define OFS_COEFHI  8'h10
`define OFS_COEFLO  8'h14
`define OFS_ACC1LO  8'h18
`define OFS_ACC1HI  8'h1c
`define OFS_ACC2LO  8'h20
`define OFS_ACC2HI  8'h24
`define OFS_CPTR    8'h28
`define OFS_XPTR    8'h2c
`define OFS_ISTS    8'h30
`define OFS_IMASK   8'h34
`define OFS_CADDR   8'h38
`define MB_FRAC     0
`define MB_PSAT     1
`define MB_RSEL     2
`define MB_WIDE     3
`define MB_ASAT     4
`define MB_SEXT     5
`define CB_FORM_HI  1
`define CB_UNSD     2
`define CB_UNSC     3
`define CB_RND      4
`define CB_W40      5
`define CB_SKIP1    6
`define CB_SKIP2    7
`define CB_EXT      8
`define CB_REP_HI   15
`define CB_REP_LO   12
`define IB_OV1      0
`define IB_OV2      1
`define IB_BERR     2
`define IB_DONE     3
`define MODE_RST    6'h00
`define RND_HALF    41'h00_0000_8000
`define MIN17       17'h1_8000
`define PMAX32      32'h7fff_ffff
`define SAT40_POS   40'h7f_ffff_ffff
`define SAT40_NEG   40'h80_0000_0000
`define SAT32_POS   40'h00_7fff_ffff
`define SAT32_NEG   40'hff_8000_0000
`define CPTR_STEP   16'h0002
`define XPTR_STEP1  16'h0001
`define XPTR_STEP2  16'h0002
`define RESP_OKAY   2'b00
`define RESP_SLVERR 2'b10
`endif

// [src/dmas_pkg.sv]
// types of the dual multiply-subtract unit
`default_nettype none
package dmas_pkg;
    typedef enum logic {idle_s, run_s} state_t;
    typedef enum logic [1:0] {form_dual, form_shared, form_long} form_t;
endpackage
`default_nettype wire

// [src/dual_multiply_subtract_unit.sv]
// dual multiply-subtract datapath with axi4-lite register access
// Notes on behaviour
// - both units multiply-subtract in one cycle
// - shared word from x bus feeds both units
// - high coefficient half feeds second unit
// - low half at partner address, first unit
// - long word: high to second, low first
// - unsigned qualifier zero extends, else sign; data word sign extends only in sign-extension mode
// - fractional mode shifts product left one
// - product saturation mode governs product overflow
// - product sign extended, subtracted from accumulator
// - rounding qualifier rounds by selected method
// - overflow sets destination accumulator flag
// - overflow saturates when saturation mode set
// - wide qualifier forces wide mode once
// - external coefficient raises bus error
// - skipped unit idle, pointers still update
// - operation repeats inside repeat loop
// - coefficient pointer plus two, data minus one, or minus two for a long word
`include "dmas_params.svh"
`default_nettype none
module dual_multiply_subtract_unit
    import dmas_pkg::*;
(
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // write address and data
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] awaddr,
    input  wire logic [2:0]  awprot,
    input  wire logic        wvalid,
    output logic             wready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    // write response
    output logic             bvalid,
    input  wire logic        bready,
    output logic [1:0]       bresp,
    // read
    input  wire logic        arvalid,
    output logic             arready,
    input  wire logic [31:0] araddr,
    input  wire logic [2:0]  arprot,
    output logic             rvalid,
    input  wire logic        rready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    // interrupt
    output logic             irq
);
    logic        awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0]  bresp_q, rresp_q;
    logic [31:0] rdata_q, wdata_q;
    logic [3:0]  wstrb_q;
    logic [7:0]  awaddr_q;
    logic [5:0]  mode_q;
    logic [15:0] cmd_q;
    logic [15:0] xdata_q, cdata_q, chi_q, clo_q, cptr_q, xptr_q;
    logic [39:0] acc1_q, acc2_q;
    logic [3:0]  ists_q, imask_q, ists_set;
    logic [3:0]  rep_q;
    logic        irq_q;
    state_t      state_q;
    form_t       form;
    logic        do_wr, start, run_ok, berr, wide;
    logic [15:0] op2;
    logic [40:0] r1, r2;
    function automatic logic [31:0] merge(input logic [31:0] old, nw,
                                          input logic [3:0]  st);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                m[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return m;
    endfunction
    function automatic logic mapped(input logic [7:0] a);
        return a <= `OFS_CADDR && a[1:0] == 2'b00;
    endfunction
    // returns {overflow, result}
    function automatic logic [40:0] mas(input logic [39:0] acc,
                                        input logic [15:0] a, b,
                                        input logic        ua, ub,
                                        input logic [5:0]  md,
                                        input logic        rnd, wd);
        logic signed [16:0] ea, eb;
        logic signed [33:0] pr;
        logic [31:0]        p;
        logic [40:0]        s;
        logic               ov;
        ea = {~ua & md[`MB_SEXT] & a[15], a};
        eb = {~ub & b[15], b};
        pr = ea * eb;
        p = md[`MB_FRAC] ? {pr[30:0], 1'b0} : pr[31:0];
        // with both operands signed, only -1 * -1 in fractional mode leaves 32-bit range
        if (md[`MB_PSAT] && md[`MB_FRAC] && ea == `MIN17 && eb == `MIN17) begin
            p = `PMAX32;
        end
        s = {acc[39], acc} - {{9{p[31]}}, p};
        if (rnd) begin
            s = s + `RND_HALF;
            if (md[`MB_RSEL] && s[15:0] == 16'h0000) begin
                s[16] = 1'b0;
            end
            s[15:0] = 16'h0000;
        end
        ov = wd ? (s[40] != s[39])
                : !(&s[40:31] || ~|s[40:31]);
        if (ov && md[`MB_ASAT]) begin
            if (wd) begin
                s[39:0] = s[40] ? `SAT40_NEG : `SAT40_POS;
            end else begin
                s[39:0] = s[40] ? `SAT32_NEG : `SAT32_POS;
            end
        end
        return {ov, s[39:0]};
    endfunction
    assign awready = awready_q;
    assign wready  = wready_q;
    assign bvalid  = bvalid_q;
    assign bresp   = bresp_q;
    assign arready = arready_q;
    assign rvalid  = rvalid_q;
    assign rdata   = rdata_q;
    assign rresp   = rresp_q;
    assign irq     = irq_q;
    // write channel: address and data taken in either order
    assign do_wr = !awready_q && !wready_q && !bvalid_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            bvalid_q  <= 1'b0;
            bresp_q   <= `RESP_OKAY;
            awaddr_q  <= 8'h00;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
        end else begin
            if (awvalid && awready_q) begin
                awready_q <= 1'b0;
                awaddr_q  <= awaddr[7:0];
            end
            if (wvalid && wready_q) begin
                wready_q <= 1'b0;
                wdata_q  <= wdata;
                wstrb_q  <= wstrb;
            end
            if (do_wr) begin
                bvalid_q <= 1'b1;
                bresp_q  <= mapped(awaddr_q) ? `RESP_OKAY : `RESP_SLVERR;
            end
            if (bvalid_q && bready) begin
                bvalid_q  <= 1'b0;
                awready_q <= 1'b1;
                wready_q  <= 1'b1;
            end
        end
    end

    // read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= `RESP_OKAY;
        end else if (arvalid && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rresp_q   <= mapped(araddr[7:0]) ? `RESP_OKAY : `RESP_SLVERR;
            case (araddr[7:0])
                `OFS_MODE:   rdata_q <= {26'h0, mode_q};
                `OFS_CMD:    rdata_q <= {15'h0, state_q == run_s, cmd_q};
                `OFS_XDATA:  rdata_q <= {16'h0, xdata_q};
                `OFS_CDATA:  rdata_q <= {16'h0, cdata_q};
                `OFS_COEFHI: rdata_q <= {16'h0, chi_q};
                `OFS_COEFLO: rdata_q <= {16'h0, clo_q};
                `OFS_ACC1LO: rdata_q <= acc1_q[31:0];
                `OFS_ACC1HI: rdata_q <= {24'h0, acc1_q[39:32]};
                `OFS_ACC2LO: rdata_q <= acc2_q[31:0];
                `OFS_ACC2HI: rdata_q <= {24'h0, acc2_q[39:32]};
                `OFS_CPTR:   rdata_q <= {16'h0, cptr_q};
                `OFS_XPTR:   rdata_q <= {16'h0, xptr_q};
                `OFS_ISTS:   rdata_q <= {28'h0, ists_q};
                `OFS_IMASK:  rdata_q <= {28'h0, imask_q};
                // partner address flips bit 0: +1 when even, -1 when odd
                `OFS_CADDR:  rdata_q <= {cptr_q ^ 16'h0001, cptr_q};
                default:     rdata_q <= 32'h0000_0000;
            endcase
        end else if (rvalid_q && rready) begin
            rvalid_q  <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    // operand routing and the two units
    assign start  = do_wr && awaddr_q == `OFS_CMD && state_q == idle_s;
    assign form   = form_t'(cmd_q[`CB_FORM_HI:0]);
    assign berr   = cmd_q[`CB_EXT];
    assign run_ok = state_q == run_s && !berr;
    assign wide   = mode_q[`MB_WIDE] | cmd_q[`CB_W40];
    // shared form feeds the x word to both; else c bus to second unit
    assign op2 = form == form_shared ? xdata_q : cdata_q;
    assign r1 = mas(acc1_q, xdata_q, clo_q, cmd_q[`CB_UNSD], cmd_q[`CB_UNSC],
                    mode_q, cmd_q[`CB_RND], wide);
    assign r2 = mas(acc2_q, op2, chi_q, cmd_q[`CB_UNSD], cmd_q[`CB_UNSC],
                    mode_q, cmd_q[`CB_RND], wide);

    // sequencer; repeat count gives extra passes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= idle_s;
            cmd_q   <= 16'h0000;
            rep_q   <= 4'h0;
        end else begin
            case (state_q)
                idle_s: begin
                    if (start) begin
                        cmd_q   <= 16'(merge({16'h0, cmd_q}, wdata_q,
                                             wstrb_q));
                        rep_q   <= wdata_q[`CB_REP_HI:`CB_REP_LO];
                        state_q <= run_s;
                    end
                end
                run_s: begin
                    if (rep_q == 4'h0 || berr) begin
                        state_q <= idle_s;
                    end else begin
                        rep_q <= rep_q - 4'h1;
                    end
                end
                default: state_q <= idle_s;
            endcase
        end
    end

    // mode and operand words; software only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_q  <= `MODE_RST;
            xdata_q <= 16'h0000;
            cdata_q <= 16'h0000;
            chi_q   <= 16'h0000;
            clo_q   <= 16'h0000;
        end else if (do_wr && state_q == idle_s) begin
            case (awaddr_q)
                `OFS_MODE:   mode_q  <= wdata_q[5:0];
                `OFS_XDATA:  xdata_q <= wdata_q[15:0];
                `OFS_CDATA:  cdata_q <= wdata_q[15:0];
                `OFS_COEFHI: chi_q   <= wdata_q[15:0];
                `OFS_COEFLO: clo_q   <= wdata_q[15:0];
                default: ;
            endcase
        end
    end

    // accumulators: a skipped unit keeps its value
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc1_q <= 40'h00_0000_0000;
            acc2_q <= 40'h00_0000_0000;
        end else if (run_ok) begin
            if (!cmd_q[`CB_SKIP1]) begin
                acc1_q <= r1[39:0];
            end
            if (!cmd_q[`CB_SKIP2]) begin
                acc2_q <= r2[39:0];
            end
        end else if (do_wr && state_q == idle_s) begin
            case (awaddr_q)
                `OFS_ACC1LO: acc1_q[31:0]  <= wdata_q;
                `OFS_ACC1HI: acc1_q[39:32] <= wdata_q[7:0];
                `OFS_ACC2LO: acc2_q[31:0]  <= wdata_q;
                `OFS_ACC2HI: acc2_q[39:32] <= wdata_q[7:0];
                default: ;
            endcase
        end
    end

    // pointers advance on every pass without a bus error, skipped unit or not
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cptr_q <= 16'h0000;
            xptr_q <= 16'h0000;
        end else if (run_ok) begin
            cptr_q <= cptr_q + `CPTR_STEP;
            xptr_q <= xptr_q - (form == form_long ? `XPTR_STEP2
                                                  : `XPTR_STEP1);
        end else if (do_wr && state_q == idle_s) begin
            if (awaddr_q == `OFS_CPTR) begin
                cptr_q <= wdata_q[15:0];
            end
            if (awaddr_q == `OFS_XPTR) begin
                xptr_q <= wdata_q[15:0];
            end
        end
    end

    // sticky status; a new event beats a same-cycle clear
    always_comb begin
        ists_set = 4'h0;
        ists_set[`IB_OV1]  = run_ok && !cmd_q[`CB_SKIP1] && r1[40];
        ists_set[`IB_OV2]  = run_ok && !cmd_q[`CB_SKIP2] && r2[40];
        ists_set[`IB_BERR] = state_q == run_s && berr;
        ists_set[`IB_DONE] = state_q == run_s && (rep_q == 4'h0 || berr);
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ists_q  <= 4'h0;
            imask_q <= 4'h0;
            irq_q   <= 1'b0;
        end else begin
            if (do_wr && awaddr_q == `OFS_ISTS) begin
                ists_q <= (ists_q & ~wdata_q[3:0]) | ists_set;
            end else begin
                ists_q <= ists_q | ists_set;
            end
            if (do_wr && awaddr_q == `OFS_IMASK) begin
                imask_q <= wdata_q[3:0];
            end
            irq_q <= |(ists_q & imask_q);
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_cptr_step: assert property (run_ok |=>
        cptr_q == $past(cptr_q) + `CPTR_STEP)
        else $error("coefficient pointer did not advance by two");
    a_xptr_step: assert property (run_ok && form != form_long |=>
        xptr_q == $past(xptr_q) - `XPTR_STEP1)
        else $error("data pointer did not move by one");
    a_ovf_flag: assert property (
        run_ok && !cmd_q[`CB_SKIP2] && r2[40] |=> ists_q[`IB_OV2])
        else $error("second overflow flag not set");
    a_sat_narrow: assert property (run_ok && !cmd_q[`CB_SKIP2]
        && r2[40] && mode_q[`MB_ASAT] && !wide |=>
        acc2_q == `SAT32_POS || acc2_q == `SAT32_NEG)
        else $error("accumulator not saturated to 32 bits");
    a_berr_hold: assert property (state_q == run_s && berr |=>
        acc1_q == $past(acc1_q) && ists_q[`IB_BERR]
        && state_q == idle_s)
        else $error("bus error did not stop the operation");
    a_skip_hold: assert property (run_ok && cmd_q[`CB_SKIP2] |=>
        acc2_q == $past(acc2_q))
        else $error("skipped unit changed its accumulator");
    a_one_cycle: assert property (
        start && wdata_q[`CB_REP_HI:`CB_REP_LO] == 4'h0 |=>
        state_q == run_s ##1 state_q == idle_s)
        else $error("single operation took more than one cycle");
    a_repeat_len: assert property (start && !wdata_q[`CB_EXT] &&
        wdata_q[`CB_REP_HI:`CB_REP_LO] == 4'h1 |=>
        state_q == run_s [*2] ##1 state_q == idle_s)
        else $error("repeat count not honoured");
    a_irq_level: assert property (
        ##1 irq_q == |($past(ists_q) & $past(imask_q)))
        else $error("interrupt does not follow masked status");
    c_overflow: cover property (run_ok && (r1[40] || r2[40]));
    c_repeat:   cover property (run_ok && rep_q != 4'h0);
    c_berr:     cover property (state_q == run_s && berr);
endmodule
`default_nettype wire

// [verif/core_bus_master.sv]
// register bus master standing in for the core side of the unit
`default_nettype none
module core_bus_master (
    // clock
    input  wire logic        aclk,
    // write channels
    output logic             awvalid,
    input  wire logic        awready,
    output logic [31:0]      awaddr,
    output logic [2:0]       awprot,
    output logic             wvalid,
    input  wire logic        wready,
    output logic [31:0]      wdata,
    output logic [3:0]       wstrb,
    input  wire logic        bvalid,
    output logic             bready,
    input  wire logic [1:0]  bresp,
    // read channels
    output logic             arvalid,
    input  wire logic        arready,
    output logic [31:0]      araddr,
    output logic [2:0]       arprot,
    input  wire logic        rvalid,
    output logic             rready,
    input  wire logic [31:0] rdata,
    input  wire logic [1:0]  rresp
);
    timeunit 1ns;
    timeprecision 1ps;

    // response readies held high: never lowered, so never driven twice
    initial begin
        {awvalid, wvalid, arvalid} = 3'h0;
        {awaddr, araddr, wdata} = {3{32'h0000_0000}};
        {awprot, arprot} = 6'h00;
        wstrb = 4'hf;
        bready = 1'b1;
        rready = 1'b1;
    end

    task automatic write_word(input logic [7:0] a, input logic [31:0] d,
                              output logic [1:0] resp);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        awaddr <= {24'h00_0000, a};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (!aw_done && awready === 1'b1) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready === 1'b1) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        resp = bresp;
    endtask

    task automatic read_word(input logic [7:0] a, output logic [31:0] d,
                             output logic [1:0] resp);
        araddr <= {24'h00_0000, a};
        arvalid <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        resp = rresp;
    endtask
endmodule
`default_nettype wire

// [verif/dual_multiply_subtract_unit_tb.sv]
// self-checking bench of the dual multiply-subtract unit
`include "dmas_params.svh"
`default_nettype none
module dual_multiply_subtract_unit_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk, aresetn, irq;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [31:0] awaddr, wdata, araddr, rdata;
    logic [3:0]  wstrb;
    logic [2:0]  awprot, arprot;
    logic [1:0]  bresp, rresp;
    int          n_mismatch = 0;
    int          checks = 0;
    int          cycles = 0;

    dual_multiply_subtract_unit dual_multiply_subtract_unit_inst (
        .aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot, .wvalid,
        .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid,
        .arready, .araddr, .arprot, .rvalid, .rready, .rdata, .rresp, .irq);
    core_bus_master core_bus_master_inst (
        .aclk, .awvalid, .awready, .awaddr, .awprot, .wvalid, .wready,
        .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready,
        .araddr, .arprot, .rvalid, .rready, .rdata, .rresp);

    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // whole run needs several hundred cycles
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            $display("[FAIL] %0t timeout", $time);
            summarize();
        end
    end

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t bit got %b want %b", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        core_bus_master_inst.write_word(a, d, r);
        chk_word({30'h0, r}, {30'h0, `RESP_OKAY});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0]  r;
        core_bus_master_inst.read_word(a, d, r);
        chk_word(d, exp);
        chk_word({30'h0, r}, {30'h0, `RESP_OKAY});
    endtask

    task automatic load(input logic [15:0] x, c, hi, lo,
                        input logic [39:0] a1, a2, input logic [15:0] cp, xp);
        wr(`OFS_XDATA, {16'h0, x});
        wr(`OFS_CDATA, {16'h0, c});
        wr(`OFS_COEFHI, {16'h0, hi});
        wr(`OFS_COEFLO, {16'h0, lo});
        wr(`OFS_ACC1LO, a1[31:0]);
        wr(`OFS_ACC1HI, {24'h0, a1[39:32]});
        wr(`OFS_ACC2LO, a2[31:0]);
        wr(`OFS_ACC2HI, {24'h0, a2[39:32]});
        wr(`OFS_CPTR, {16'h0, cp});
        wr(`OFS_XPTR, {16'h0, xp});
    endtask

    // poll busy with a bound; a stuck unit counts as a mismatch
    task automatic run(input logic [31:0] cmd);
        logic [31:0] d;
        logic [1:0]  r;
        wr(`OFS_CMD, cmd);
        repeat (20) begin
            core_bus_master_inst.read_word(`OFS_CMD, d, r);
            if (d[16] === 1'b0) break;
        end
        chk_bit(d[16], 1'b0);
    endtask

    task automatic acc_is(input logic [39:0] a1, a2);
        rd(`OFS_ACC1LO, a1[31:0]);
        rd(`OFS_ACC1HI, {24'h0, a1[39:32]});
        rd(`OFS_ACC2LO, a2[31:0]);
        rd(`OFS_ACC2HI, {24'h0, a2[39:32]});
    endtask

    task automatic test_reset();
        logic [31:0] d;
        logic [1:0]  r;
        rd(`OFS_MODE, 32'h0);
        rd(`OFS_ISTS, 32'h0);
        chk_bit(irq, 1'b0);
        core_bus_master_inst.read_word(8'h3c, d, r);
        chk_word(d, 32'h0);
        chk_word({30'h0, r}, {30'h0, `RESP_SLVERR});
        core_bus_master_inst.write_word(8'h3c, 32'h1, r);
        chk_word({30'h0, r}, {30'h0, `RESP_SLVERR});
    endtask

    task automatic test_shared();
        wr(`OFS_MODE, 32'h0);
        load(16'hfe00, 16'h0, 16'h8000, 16'h4000, 40'h8000, 40'h8000,
             16'h2000, 16'h10ff);
        run(32'h0d);
        acc_is(40'hff_c080_8000, 40'hff_8100_8000);
        rd(`OFS_CPTR, 32'h2002);
        rd(`OFS_XPTR, 32'h10fe);
        rd(`OFS_CADDR, 32'h2003_2002);
        wr(`OFS_CPTR, 32'h2001);
        rd(`OFS_CADDR, 32'h2000_2001);
        rd(`OFS_ISTS, 32'h8);
    endtask

    task automatic test_long();
        wr(`OFS_ISTS, 32'hf);
        wr(`OFS_MODE, 32'h31);
        load(16'h0002, 16'h8000, 16'h7fff, 16'h0003, 40'h0, 40'h10_0000,
             16'h2000, 16'h10fe);
        run(32'h02);
        acc_is(40'hff_ffff_fff4, 40'h00_7fff_ffff);
        rd(`OFS_XPTR, 32'h10fc);
        rd(`OFS_ISTS, 32'ha);
        chk_bit(irq, 1'b0);
        wr(`OFS_IMASK, 32'h2);
        repeat (2) @(posedge aclk);
        chk_bit(irq, 1'b1);
        wr(`OFS_ISTS, 32'h2);
        repeat (2) @(posedge aclk);
        chk_bit(irq, 1'b0);
        load(16'h0002, 16'h8000, 16'h7fff, 16'h0003, 40'h0, 40'h10_0000,
             16'h2000, 16'h10fe);
        run(32'h22);
        acc_is(40'hff_ffff_fff4, 40'h00_800f_0000);
        rd(`OFS_MODE, 32'h31);
        rd(`OFS_ISTS, 32'h8);
    endtask

    task automatic test_round();
        wr(`OFS_MODE, 32'h0);
        load(16'h1, 16'h0, 16'h1, 16'h1, 40'h8001, 40'h8001, 16'h0, 16'h10);
        run(32'h11);
        acc_is(40'h1_0000, 40'h1_0000);
        wr(`OFS_MODE, 32'h4);
        load(16'h1, 16'h0, 16'h1, 16'h1, 40'h8001, 40'h8001, 16'h0, 16'h10);
        run(32'h91);
        acc_is(40'h0, 40'h8001);
        rd(`OFS_XPTR, 32'hf);
        rd(`OFS_CPTR, 32'h2);
    endtask

    // dual form: x word to first unit, c word to second
    task automatic test_dual();
        wr(`OFS_MODE, 32'h0);
        load(16'h2, 16'h3, 16'h4, 16'h5, 40'h100, 40'h100, 16'h0, 16'h10);
        run(32'h40);
        acc_is(40'h100, 40'hf4);
        rd(`OFS_XPTR, 32'hf);
        run(32'h0);
        acc_is(40'hf6, 40'he8);
    endtask

    task automatic test_sat_repeat();
        logic [31:0] d;
        logic [1:0]  r;
        wr(`OFS_ISTS, 32'hf);
        wr(`OFS_MODE, 32'h23);
        load(16'h8000, 16'h0, 16'h8000, 16'h8000, 40'h0, 40'h0,
             16'h100, 16'h200);
        run(32'h1001);
        acc_is(40'hff_0000_0002, 40'hff_0000_0002);
        rd(`OFS_CPTR, 32'h104);
        rd(`OFS_XPTR, 32'h1fe);
        rd(`OFS_ISTS, 32'hb);
        wr(`OFS_ISTS, 32'hf);
        run(32'h101);
        acc_is(40'hff_0000_0002, 40'hff_0000_0002);
        rd(`OFS_CPTR, 32'h104);
        core_bus_master_inst.read_word(`OFS_ISTS, d, r);
        chk_bit(d[`IB_BERR], 1'b1);
    endtask

    initial begin
        aresetn = 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        test_reset();
        test_shared();
        test_long();
        test_round();
        test_dual();
        test_sat_repeat();
        summarize();
    end
endmodule
`default_nettype wire
